// file: logic/bsp_pkg.sv
package bsp_pkg;
    localparam int WORD_W = 36;
    localparam int ADDR_W = 21;
    localparam int LANES = 4;
    localparam int LANE_W = 9;
    localparam int SYNC_STAGES = 3;
    localparam int BUF_DEPTH = 2;
    localparam int LAT_NORMAL = 2;
    localparam int LAT_BYPASS = 1;
    localparam logic [WORD_W-1:0] Q_RESET = 36'h0_0000_0000;
    localparam logic [ADDR_W-1:0] ADDR_RESET = 21'h00_0000;
    localparam logic [1:0] PIPE_RESET = 2'h0;

    // pin bundle as sampled through the input synchroniser
    typedef struct packed {
        logic strobe_pos;
        logic strobe_neg;
        logic read_port_sel_n;
        logic write_port_sel_n;
        logic pll_bypass_n;
        logic [LANES-1:0] byte_write_sel_n;
        logic [ADDR_W-1:0] addr;
        logic [WORD_W-1:0] d;
    } bsp_pins_t;

    // one half of a write burst waiting for the array
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [WORD_W-1:0] data;
        logic [LANES-1:0] byte_write_sel_n;
    } bsp_wr_t;

    localparam bsp_pins_t PINS_RESET = '{
        strobe_pos: 1'b1, strobe_neg: 1'b1, read_port_sel_n: 1'b1,
        write_port_sel_n: 1'b1, pll_bypass_n: 1'b1, byte_write_sel_n: 4'hf,
        addr: 21'h00_0000, d: 36'h0_0000_0000};
    localparam bsp_wr_t WR_RESET = '{
        addr: 21'h00_0000, data: 36'h0_0000_0000, byte_write_sel_n: 4'hf};
endpackage : bsp_pkg

// file: logic/bsp_port.sv
`timescale 1ns/100ps
// Overview of operation
// - write starts on positive strobe rise with write select; A then A+1 on negative rise
// - read request at cycle t returns word A at t+2 positive, A+1 next negative
// - after reset both ports idle and read outputs high impedance
// - second burst word address is the latched start address plus one
// - write data captured and read data launched on rises of both strobes
// - all byte selects low store all 36 bits of the word
// - byte select 0 alone stores bits 8..0 only
// - byte select 1 alone stores bits 17..9 only
// - byte select 2 alone stores bits 26..18 only
// - byte select 3 alone stores bits 35..27 only
// - all byte selects high leave the word unchanged for that half
// - byte selects sampled separately for each half of a write burst
// - deselected read port finishes bursts then floats after next positive rise
// - bypass pin low gives read latency of one cycle instead of two
// - same-location read returns newest data, forwarding writes still buffered
module bsp_port #(
    parameter int DEPTH_LOG2 = bsp_pkg::ADDR_W
) (
    input wire logic clk, // 50 MHz system clock
    input wire logic rst_n, // synchronous reset, active low
    input wire logic ref_strobe_pos, // positive reference strobe pin
    input wire logic ref_strobe_neg, // negative reference strobe pin
    input wire logic read_port_sel_n, // read port select, active low
    input wire logic write_port_sel_n, // write port select, active low
    input wire logic pll_bypass_n, // low selects one-cycle read latency
    input wire logic [bsp_pkg::LANES-1:0] byte_write_sel_n, // lane write selects, active low
    input wire logic [bsp_pkg::ADDR_W-1:0] addr, // shared address bus
    input wire logic [bsp_pkg::WORD_W-1:0] d, // write data port
    output logic [bsp_pkg::WORD_W-1:0] q, // read data port, registered
    output logic q_oe, // read data output enable, high while driving
    output logic wr_buf_ready // write buffer has room for another half
);
    localparam int BUF_DEPTH = bsp_pkg::BUF_DEPTH;

    function automatic logic [bsp_pkg::WORD_W-1:0] lane_merge(
        input logic [bsp_pkg::WORD_W-1:0] old_w,
        input logic [bsp_pkg::WORD_W-1:0] new_w,
        input logic [bsp_pkg::LANES-1:0] sel_n);
        logic [bsp_pkg::WORD_W-1:0] res;
        res = old_w;
        for (int i = 0; i < bsp_pkg::LANES; i++) begin
            if (!sel_n[i]) begin
                res[i*bsp_pkg::LANE_W +: bsp_pkg::LANE_W] =
                    new_w[i*bsp_pkg::LANE_W +: bsp_pkg::LANE_W];
            end
        end
        return res;
    endfunction : lane_merge

    // input synchroniser; data rides the same stages so it stays aligned with the strobes
    bsp_pkg::bsp_pins_t pins_in;
    bsp_pkg::bsp_pins_t s1_r, s2_r, s3_r;
    logic pos_lvl_r, neg_lvl_r;

    assign pins_in = '{strobe_pos: ref_strobe_pos, strobe_neg: ref_strobe_neg,
        read_port_sel_n: read_port_sel_n, write_port_sel_n: write_port_sel_n,
        pll_bypass_n: pll_bypass_n, byte_write_sel_n: byte_write_sel_n,
        addr: addr, d: d};

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s1_r <= bsp_pkg::PINS_RESET;
            s2_r <= bsp_pkg::PINS_RESET;
            s3_r <= bsp_pkg::PINS_RESET;
        end else begin
            s1_r <= pins_in;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end

    // a strobe level only counts once stages two and three agree
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pos_lvl_r <= 1'b1;
            neg_lvl_r <= 1'b1;
        end else begin
            if (s2_r.strobe_pos == s3_r.strobe_pos) pos_lvl_r <= s3_r.strobe_pos;
            if (s2_r.strobe_neg == s3_r.strobe_neg) neg_lvl_r <= s3_r.strobe_neg;
        end
    end

    // no rise while strobes stand still, so every register below holds except the write buffer, which keeps draining
    wire pos_rise = s2_r.strobe_pos && s3_r.strobe_pos && !pos_lvl_r;
    wire neg_rise = s2_r.strobe_neg && s3_r.strobe_neg && !neg_lvl_r && !pos_rise;
    wire rd_start = pos_rise && !s3_r.read_port_sel_n;
    wire wr_start = pos_rise && !s3_r.write_port_sel_n;
    wire lat_two = s3_r.pll_bypass_n;

    // checker-only history of read requests, one bit per positive rise;
    // kept apart from the scheduler so the latency select is checked on its own
    logic [1:0] rd_hist_r;
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rd_hist_r <= bsp_pkg::PIPE_RESET;
        end else if (pos_rise) begin
            rd_hist_r <= {rd_hist_r[0], rd_start};
        end
    end

    // read scheduling: one slot per positive rise
    logic [1:0] rd_sr_r;
    logic [bsp_pkg::ADDR_W-1:0] rd_addr0_r, rd_addr1_r, burst_addr_r;
    logic second_due_r;

    wire launch_due = pos_rise && (lat_two ? rd_sr_r[1] : rd_sr_r[0]);
    wire [bsp_pkg::ADDR_W-1:0] launch_addr = lat_two ? rd_addr1_r : rd_addr0_r;
    wire second_fire = neg_rise && second_due_r;
    wire rd_fetch = launch_due || second_fire;
    wire [bsp_pkg::ADDR_W-1:0] burst_next = burst_addr_r + 21'h00_0001;
    wire [bsp_pkg::ADDR_W-1:0] fetch_addr = launch_due ? launch_addr : burst_next;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rd_sr_r <= bsp_pkg::PIPE_RESET;
            rd_addr0_r <= bsp_pkg::ADDR_RESET;
            rd_addr1_r <= bsp_pkg::ADDR_RESET;
        end else if (pos_rise) begin
            rd_sr_r <= {rd_sr_r[0], rd_start};
            rd_addr0_r <= s3_r.addr;
            rd_addr1_r <= rd_addr0_r;
        end
    end

    // write capture: first half on positive rise, second half on the next negative rise
    logic wr_pend_r;
    logic [bsp_pkg::ADDR_W-1:0] wr_addr_r;
    bsp_pkg::bsp_wr_t push_ent;

    wire push_req = wr_start || (neg_rise && wr_pend_r);
    wire [bsp_pkg::ADDR_W-1:0] wr_next = wr_addr_r + 21'h00_0001;
    assign push_ent = '{addr: wr_start ? s3_r.addr : wr_next, data: s3_r.d,
        byte_write_sel_n: s3_r.byte_write_sel_n};

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wr_pend_r <= 1'b0;
            wr_addr_r <= bsp_pkg::ADDR_RESET;
        end else if (wr_start) begin
            wr_pend_r <= 1'b1;
            wr_addr_r <= s3_r.addr;
        end else if (neg_rise) begin
            wr_pend_r <= 1'b0;
        end
    end

    // two-entry write buffer; array reads win, so draining stalls and the buffer can fill
    bsp_pkg::bsp_wr_t buf_r [BUF_DEPTH];
    logic buf_rptr_r, buf_wptr_r;
    logic [1:0] buf_cnt_r;
    logic [bsp_pkg::WORD_W-1:0] mem [2**DEPTH_LOG2];

    assign wr_buf_ready = buf_cnt_r != 2'h2;
    wire push = push_req && wr_buf_ready;
    wire drain = (buf_cnt_r != 2'h0) && !rd_fetch;
    wire [1:0] cnt_nxt = buf_cnt_r + {1'b0, push} - {1'b0, drain};
    bsp_pkg::bsp_wr_t head;
    assign head = buf_r[buf_rptr_r];
    wire [DEPTH_LOG2-1:0] head_idx = head.addr[DEPTH_LOG2-1:0];
    wire [bsp_pkg::WORD_W-1:0] head_merged = lane_merge(mem[head_idx], head.data,
        head.byte_write_sel_n);

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            buf_rptr_r <= 1'b0;
            buf_wptr_r <= 1'b0;
            buf_cnt_r <= 2'h0;
            for (int i = 0; i < BUF_DEPTH; i++) buf_r[i] <= bsp_pkg::WR_RESET;
        end else begin
            if (push) begin
                buf_r[buf_wptr_r] <= push_ent;
                buf_wptr_r <= !buf_wptr_r;
            end
            if (drain) buf_rptr_r <= !buf_rptr_r;
            buf_cnt_r <= cnt_nxt;
        end
    end

    always_ff @(posedge clk) begin
        if (drain) mem[head_idx] <= head_merged;
    end

    // coherent read: array word overlaid by buffered halves, oldest first, then the live one
    logic [bsp_pkg::WORD_W-1:0] rd_word;
    always_comb begin
        logic ptr;
        ptr = buf_rptr_r;
        rd_word = mem[fetch_addr[DEPTH_LOG2-1:0]];
        for (int i = 0; i < BUF_DEPTH; i++) begin
            if (i < buf_cnt_r && buf_r[ptr].addr == fetch_addr) begin
                rd_word = lane_merge(rd_word, buf_r[ptr].data, buf_r[ptr].byte_write_sel_n);
            end
            ptr = !ptr;
        end
        if (push && push_ent.addr == fetch_addr) begin
            rd_word = lane_merge(rd_word, push_ent.data, push_ent.byte_write_sel_n);
        end
    end

    // output stage: enable follows each positive rise, so a gap floats the bus
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            q <= bsp_pkg::Q_RESET;
            q_oe <= 1'b0;
            second_due_r <= 1'b0;
            burst_addr_r <= bsp_pkg::ADDR_RESET;
        end else if (pos_rise) begin
            q_oe <= launch_due;
            second_due_r <= launch_due;
            if (launch_due) begin
                q <= rd_word;
                burst_addr_r <= launch_addr;
            end
        end else if (second_fire) begin
            q <= rd_word;
            second_due_r <= 1'b0;
        end
    end

    out_reset_a: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(rst_n) |-> !q_oe)
        else $error("read outputs driven right after reset");
    launch_first_a: assert property (@(posedge clk) disable iff (!rst_n)
        launch_due |=> q_oe && q == $past(rd_word))
        else $error("first burst word not launched on positive rise");
    launch_second_a: assert property (@(posedge clk) disable iff (!rst_n)
        second_fire |=> q_oe && q == $past(rd_word) && $past(fetch_addr) == $past(burst_next))
        else $error("second burst word wrong or not launched");
    idle_float_a: assert property (@(posedge clk) disable iff (!rst_n)
        pos_rise && !launch_due |=> !q_oe ##1 (!q_oe || pos_rise))
        else $error("read outputs not floated after idle positive rise");
    lat_two_a: assert property (@(posedge clk) disable iff (!rst_n)
        pos_rise && lat_two |-> launch_due == rd_hist_r[1])
        else $error("normal latency launch not two rises after request");

    lat_one_a: assert property (@(posedge clk) disable iff (!rst_n)
        pos_rise && !lat_two |-> launch_due == rd_hist_r[0])
        else $error("bypass latency launch not one rise after request");

    wr_first_a: assert property (@(posedge clk) disable iff (!rst_n)
        wr_start && wr_buf_ready |-> push && push_ent.addr == s3_r.addr)
        else $error("first write half captured at wrong address");

    wr_second_a: assert property (@(posedge clk) disable iff (!rst_n)
        neg_rise && wr_pend_r |-> push_req && push_ent.addr == wr_addr_r + 21'h00_0001)
        else $error("second write half captured at wrong address");

    wr_pend_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
        neg_rise |=> !wr_pend_r)
        else $error("write burst still pending after negative rise");

    buf_bound_a: assert property (@(posedge clk) disable iff (!rst_n)
        buf_cnt_r != 2'h3)
        else $error("write buffer count beyond two entries");

    full_block_a: assert property (@(posedge clk) disable iff (!rst_n)
        !wr_buf_ready |-> !push)
        else $error("write half pushed into full buffer");

    full_flag_a: assert property (@(posedge clk) disable iff (!rst_n)
        buf_cnt_r == 2'h2 |-> !wr_buf_ready)
        else $error("buffer ready while both entries used");

    rise_excl_a: assert property (@(posedge clk) disable iff (!rst_n)
        pos_rise |-> !neg_rise)
        else $error("both strobe rises seen in one clock");

    sync_agree_a: assert property (@(posedge clk) disable iff (!rst_n)
        $changed(pos_lvl_r) |-> $past(s2_r.strobe_pos) == $past(s3_r.strobe_pos))
        else $error("strobe level taken before stages agreed");

    oe_follow_a: assert property (@(posedge clk) disable iff (!rst_n)
        pos_rise |=> q_oe == $past(launch_due))
        else $error("output enable not set by positive rise");

    nop_float_a: assert property (@(posedge clk) disable iff (!rst_n)
        pos_rise && s3_r.read_port_sel_n && rd_hist_r == 2'h0 |=> !q_oe)
        else $error("outputs driven after idle cycles");

    burst_addr_a: assert property (@(posedge clk) disable iff (!rst_n)
        second_fire && !pos_rise |-> fetch_addr == burst_addr_r + 21'h00_0001)
        else $error("second burst word fetched from wrong address");

    reset_idle_a: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(rst_n) |-> wr_buf_ready && !wr_pend_r && !second_due_r)
        else $error("ports not idle right after reset");

    lane_sel_a: assert property (@(posedge clk) disable iff (!rst_n)
        push |=> buf_r[$past(buf_wptr_r)].byte_write_sel_n == $past(s3_r.byte_write_sel_n))
        else $error("byte selects not stored with their half");
    drain_merge_a: assert property (@(posedge clk) disable iff (!rst_n)
        drain |=> mem[$past(head_idx)] == $past(head_merged))
        else $error("array word not updated from buffer head");
    hold_still_a: assert property (@(posedge clk) disable iff (!rst_n)
        !pos_rise && !second_fire |=> $stable(q) && $stable(q_oe))
        else $error("outputs moved without a strobe rise");
endmodule : bsp_port

// file: tb/bsp_ctrl_model.sv
`timescale 1ns/100ps
module bsp_ctrl_model (
    input wire logic clk, // system clock
    output logic ref_strobe_pos, // positive strobe
    output logic ref_strobe_neg, // negative strobe
    output logic read_port_sel_n, // read select
    output logic write_port_sel_n, // write select
    output logic pll_bypass_n, // latency select
    output logic [bsp_pkg::LANES-1:0] byte_write_sel_n, // lane selects
    output logic [bsp_pkg::ADDR_W-1:0] addr, // start address
    output logic [bsp_pkg::WORD_W-1:0] d, // write data
    input wire logic [bsp_pkg::WORD_W-1:0] q, // read data
    input wire logic q_oe // read enable
);
    initial begin
        ref_strobe_pos = 1'b1;
        ref_strobe_neg = 1'b1;
        read_port_sel_n = 1'b1;
        write_port_sel_n = 1'b1;
        pll_bypass_n = 1'b1;
        byte_write_sel_n = 4'hf;
        addr = 21'h15_5555;
        d = 36'h5_5555_5555;
    end
    task automatic wait_clk(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : wait_clk
    task automatic set_bypass(input logic v);
        pll_bypass_n = v;
    endtask : set_bypass
    // one strobe period; pins settle three clocks before the positive rise and one before the negative, and hold five after each,
    // since the port sees them through a three-flop synchroniser
    task automatic cycle(input logic rn, wn, input logic [20:0] a, input logic [35:0] d0,
            input logic [3:0] b0, input logic [35:0] d1, input logic [3:0] b1,
            output logic [35:0] qa, output logic oa, output logic [35:0] qb, output logic ob);
        read_port_sel_n = rn;
        write_port_sel_n = wn;
        addr = a;
        d = d0;
        byte_write_sel_n = b0;
        ref_strobe_pos = 1'b0;
        wait_clk(3);
        ref_strobe_pos = 1'b1;
        ref_strobe_neg = 1'b0;
        wait_clk(5);
        qa = q;
        oa = q_oe;
        read_port_sel_n = 1'b1;
        write_port_sel_n = 1'b1;
        addr = ~a;
        d = d1;
        byte_write_sel_n = b1;
        wait_clk(1);
        ref_strobe_neg = 1'b1;
        wait_clk(5);
        qb = q;
        ob = q_oe;
        d = ~d1;
        byte_write_sel_n = 4'hf;
    endtask : cycle
endmodule : bsp_ctrl_model

// file: tb/burst_sram_port_control_tb_top.sv
`timescale 1ns/100ps
module burst_sram_port_control_tb_top;
    logic clk;
    logic rst_n;
    logic ref_strobe_pos, ref_strobe_neg, read_port_sel_n, write_port_sel_n;
    logic pll_bypass_n, q_oe, wr_buf_ready, oa, ob;
    logic [3:0] byte_write_sel_n;
    logic [20:0] addr;
    logic [35:0] d, q, qa, qb;
    logic [35:0] mem [int];
    int num_errors = 0;
    int n_tests = 0;

    bsp_port #(.DEPTH_LOG2(8)) bsp_port_inst (.clk, .rst_n, .ref_strobe_pos, .ref_strobe_neg,
        .read_port_sel_n, .write_port_sel_n, .pll_bypass_n, .byte_write_sel_n, .addr, .d,
        .q, .q_oe, .wr_buf_ready);
    bsp_ctrl_model bsp_ctrl_model_inst (.clk, .ref_strobe_pos, .ref_strobe_neg,
        .read_port_sel_n, .write_port_sel_n, .pll_bypass_n, .byte_write_sel_n, .addr, .d,
        .q, .q_oe);

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    function automatic logic [35:0] merge(input logic [35:0] o, n, input logic [3:0] s);
        merge = o;
        for (int i = 0; i < 4; i++) begin
            if (!s[i]) merge[i*9 +: 9] = n[i*9 +: 9];
        end
    endfunction : merge
    task automatic chk_w(input logic [35:0] got, exp, input string m);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t: %s got %h exp %h", $time, m, got, exp);
        end
    endtask : chk_w
    task automatic chk_f(input logic got, exp, input string m);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t: %s got %b", $time, m, got);
        end
    endtask : chk_f
    task automatic cyc(input logic rn, wn, input logic [20:0] a, input logic [35:0] d0,
            input logic [3:0] b0, input logic [35:0] d1, input logic [3:0] b1);
        bsp_ctrl_model_inst.cycle(rn, wn, a, d0, b0, d1, b1, qa, oa, qb, ob);
        if (!wn) begin
            mem[a] = merge(mem[a], d0, b0);
            mem[a + 1] = merge(mem[a + 1], d1, b1);
        end
    endtask : cyc
    // idle period with every lane enabled: a deselected write must still store nothing
    task automatic nop();
        cyc(1'b1, 1'b1, 21'h20, 36'hf_0f0f_0f0f, 4'h0, 36'hf_0f0f_0f0f, 4'h0);
    endtask : nop
    task automatic rd(input logic [20:0] a);
        cyc(1'b0, 1'b1, a, 36'h0, 4'hf, 36'h0, 4'hf);
    endtask : rd
    task automatic chk_burst(input logic [20:0] a);
        chk_f(oa, 1'b1, "oe word A");
        chk_w(qa, mem[a], "word A");
        chk_w(qb, mem[a + 1], "word A+1");
    endtask : chk_burst
    task automatic rd_check(input logic [20:0] a, input int lat, input int stall);
        rd(a);
        repeat (lat) nop();
        chk_burst(a);
        repeat (stall) bsp_ctrl_model_inst.wait_clk(1);
        chk_w(q, mem[a + 1], "held data");
        chk_f(q_oe, 1'b1, "held oe");
        nop();
        chk_f(oa, 1'b0, "oe after burst");
    endtask : rd_check
    task automatic t_burst();
        cyc(1'b1, 1'b0, 21'h20, 36'h1_2345_6789, 4'h0, 36'h9_8765_4321, 4'h0);
        chk_f(wr_buf_ready, 1'b1, "buffer room");
        rd_check(21'h20, 2, 20);
        $display("burst test done");
    endtask : t_burst
    task automatic t_lanes();
        logic [3:0] b0, b1;
        logic [20:0] a;
        for (int i = 0; i < 5; i++) begin
            a = 21'h40 + 21'(4 * i);
            b0 = (i < 4) ? ~(4'h1 << i) : 4'hf;
            b1 = ~(4'h1 << ((i + 1) % 4));
            cyc(1'b1, 1'b0, a, 36'h0, 4'h0, 36'h0, 4'h0);
            cyc(1'b1, 1'b0, a, 36'hf_ffff_ffff, b0, 36'ha_aaaa_aaaa, b1);
            rd_check(a, 2, 0);
        end
        $display("lane test done");
    endtask : t_lanes
    task automatic t_forward();
        cyc(1'b1, 1'b0, 21'h60, 36'h3_1111_2222, 4'h0, 36'h4_3333_4444, 4'h0);
        rd(21'h60);
        rd(21'h20);
        nop();
        chk_burst(21'h60);
        nop();
        chk_burst(21'h20);
        nop();
        chk_f(oa, 1'b0, "oe after reads");
        $display("forward test done");
    endtask : t_forward
    task automatic t_bypass();
        bsp_ctrl_model_inst.set_bypass(1'b0);
        bsp_ctrl_model_inst.wait_clk(8);
        rd_check(21'h60, 1, 0);
        bsp_ctrl_model_inst.set_bypass(1'b1);
        $display("bypass test done");
    endtask : t_bypass
    task automatic finish_test();
        $display("checks %0d, mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : finish_test
    // the sequence needs under 1000 clocks; twice that means a hang
    initial begin
        repeat (2000) @(posedge clk);
        num_errors++;
        $display("unexpected at %0t: watchdog expired", $time);
        finish_test();
    end
    initial begin
        rst_n = 1'b0;
        repeat (2) @(posedge clk);
        #1 rst_n = 1'b1;
        bsp_ctrl_model_inst.wait_clk(1);
        chk_f(q_oe, 1'b0, "reset oe");
        chk_w(q, 36'h0, "reset q");
        chk_f(wr_buf_ready, 1'b1, "reset ready");
        t_burst();
        t_lanes();
        t_forward();
        t_bypass();
        finish_test();
    end
endmodule : burst_sram_port_control_tb_top
